// ==== adm_core.sv ====
// Summary of operation
// - Monitor active only when its enable set
// - Matching result raises that monitor's own interrupt
// - Compare only when result is being stored
// - Compare never clears stored flag; reads do
// - Unread result overwritten sets overrun flag
// - Soft interrupt after all programmed slots converted
// - Clearing enable aborts conversion, nothing stored
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
module adm_core import adm_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   output logic core_start,
   output logic [4:0] core_chan,
   output logic core_abort,
   input wire logic core_done,
   input wire logic [11:0] core_data,
   output logic monitor_a_irq,
   output logic monitor_b_irq,
   output logic soft_done_irq,
   output logic irq
);
   typedef struct packed {
      adm_seq_e state;
      logic converter_enable;
      logic [3:0] idx;
      logic core_start;
      logic [4:0] chan;
      logic core_abort;
      logic soft_done;
      logic [11:0][11:0] res;
      logic [11:0] stored;
      logic [11:0] ovr;
      logic [11:0][7:0] slot;
      logic [1:0][7:0] mon_ctrl;
      logic [1:0][11:0] mon_val;
      logic [31:0] rdata;
   } adm_core_s;

   adm_core_s st_ff;
   adm_core_s nxt_st;

   logic mode_wr;
   logic en_clear;
   logic store_v;
   logic rd_res;
   logic [3:0] rd_idx;
   logic hit_a;
   logic hit_b;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] irq_events;

   assign mode_wr = wr_en && (addr == OFS_MODE);
   assign en_clear = mode_wr && !wr_data[MODE_EN_BIT];
   // A store is suppressed in the cycle the converter is disabled
   assign store_v = (st_ff.state == ADM_CONV) && core_done && !en_clear;
   assign rd_res = rd_en && res_hit(addr);
   assign rd_idx = res_sel(addr);

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.core_start = 1'b0;
      nxt_st.core_abort = 1'b0;
      nxt_st.soft_done = 1'b0;
      nxt_st.rdata = 32'h0;

      if (mode_wr)
         nxt_st.converter_enable = wr_data[MODE_EN_BIT];

      unique case (st_ff.state)
         ADM_IDLE:
         begin
            if (mode_wr && wr_data[MODE_START_BIT] && wr_data[MODE_EN_BIT])
            begin
               nxt_st.idx = 4'h0;
               nxt_st.state = ADM_SCAN;
            end
         end
         ADM_SCAN:
         begin
            if (st_ff.slot[st_ff.idx][SLOT_EN_BIT])
            begin
               nxt_st.core_start = 1'b1;
               nxt_st.chan = st_ff.slot[st_ff.idx][CHAN_W-1:0];
               nxt_st.state = ADM_CONV;
            end
            else if (st_ff.idx == LAST_SLOT)
            begin
               nxt_st.soft_done = 1'b1;
               nxt_st.state = ADM_IDLE;
            end
            else
               nxt_st.idx = st_ff.idx + 4'h1;
         end
         ADM_CONV:
         begin
            if (core_done)
            begin
               if (st_ff.idx == LAST_SLOT)
               begin
                  nxt_st.soft_done = 1'b1;
                  nxt_st.state = ADM_IDLE;
               end
               else
               begin
                  nxt_st.idx = st_ff.idx + 4'h1;
                  nxt_st.state = ADM_SCAN;
               end
            end
         end
         default:
            nxt_st.state = ADM_IDLE;
      endcase

      // Disabling stops the sequence at once and aborts the core if it is converting
      if (en_clear && st_ff.state != ADM_IDLE)
      begin
         nxt_st.state = ADM_IDLE;
         nxt_st.core_start = 1'b0;
         nxt_st.core_abort = st_ff.state == ADM_CONV;
         nxt_st.soft_done = 1'b0;
      end

      // Only a software read clears the result flags
      if (rd_res)
      begin
         nxt_st.stored[rd_idx] = 1'b0;
         nxt_st.ovr[rd_idx] = 1'b0;
      end

      if (store_v)
      begin
         nxt_st.res[st_ff.idx] = core_data;
         nxt_st.stored[st_ff.idx] = 1'b1;
         if (st_ff.stored[st_ff.idx] && !(rd_res && rd_idx == st_ff.idx))
            nxt_st.ovr[st_ff.idx] = 1'b1;
      end

      if (wr_en)
      begin
         case (addr)
            OFS_SLOT_0_3:
               nxt_st.slot[3:0] = wr_data & SLOT_WR_MASK;
            OFS_SLOT_4_7:
               nxt_st.slot[7:4] = wr_data & SLOT_WR_MASK;
            OFS_SLOT_8_11:
               nxt_st.slot[11:8] = wr_data & SLOT_WR_MASK;
            OFS_MON_A_CTRL:
               nxt_st.mon_ctrl[0] = wr_data[7:0] & MON_CTRL_MASK;
            OFS_MON_B_CTRL:
               nxt_st.mon_ctrl[1] = wr_data[7:0] & MON_CTRL_MASK;
            OFS_MON_A_VALUE:
               nxt_st.mon_val[0] = wr_data[DATA_W-1:0];
            OFS_MON_B_VALUE:
               nxt_st.mon_val[1] = wr_data[DATA_W-1:0];
            default:
               nxt_st.rdata = 32'h0;
         endcase
      end

      if (rd_en)
      begin
         case (addr)
            OFS_MODE:
            begin
               nxt_st.rdata[MODE_EN_BIT] = st_ff.converter_enable;
               nxt_st.rdata[MODE_BUSY_BIT] = st_ff.state != ADM_IDLE;
            end
            OFS_SLOT_0_3:
               nxt_st.rdata = st_ff.slot[3:0];
            OFS_SLOT_4_7:
               nxt_st.rdata = st_ff.slot[7:4];
            OFS_SLOT_8_11:
               nxt_st.rdata = st_ff.slot[11:8];
            OFS_MON_A_CTRL:
               nxt_st.rdata[7:0] = st_ff.mon_ctrl[0];
            OFS_MON_B_CTRL:
               nxt_st.rdata[7:0] = st_ff.mon_ctrl[1];
            OFS_MON_A_VALUE:
               nxt_st.rdata[DATA_W-1:0] = st_ff.mon_val[0];
            OFS_MON_B_VALUE:
               nxt_st.rdata[DATA_W-1:0] = st_ff.mon_val[1];
            OFS_IRQ_STATUS:
               nxt_st.rdata[NUM_EV-1:0] = irq_status;
            OFS_IRQ_MASK:
               nxt_st.rdata[NUM_EV-1:0] = irq_mask;
            default:
            begin
               if (rd_res)
               begin
                  nxt_st.rdata[DATA_W-1:0] = st_ff.res[rd_idx];
                  nxt_st.rdata[RES_STORED_BIT] = st_ff.stored[rd_idx];
                  nxt_st.rdata[RES_OVR_BIT] = st_ff.ovr[rd_idx];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_ff <= '0;
         st_ff.slot <= SLOT_RST;
         st_ff.mon_ctrl <= {MON_CTRL_RST, MON_CTRL_RST};
         st_ff.mon_val <= {MON_VALUE_RST, MON_VALUE_RST};
      end
      else
         st_ff <= nxt_st;
   end

   // Both monitors see the store as it is written, not as a read
   adm_monitor u_mon_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .store_valid(store_v),
      .store_index(st_ff.idx),
      .store_data(core_data),
      .enable(st_ff.mon_ctrl[0][MON_EN_BIT]),
      .condition(st_ff.mon_ctrl[0][MON_COND_BIT]),
      .select(st_ff.mon_ctrl[0][3:0]),
      .value(st_ff.mon_val[0]),
      .hit(hit_a)
   );

   adm_monitor u_mon_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .store_valid(store_v),
      .store_index(st_ff.idx),
      .store_data(core_data),
      .enable(st_ff.mon_ctrl[1][MON_EN_BIT]),
      .condition(st_ff.mon_ctrl[1][MON_COND_BIT]),
      .select(st_ff.mon_ctrl[1][3:0]),
      .value(st_ff.mon_val[1]),
      .hit(hit_b)
   );

   assign irq_events = {hit_b, hit_a, st_ff.soft_done};

   adm_irq u_irq (
      .clk(clk),
      .sys_rst(sys_rst),
      .event_in(irq_events),
      .status_wr(wr_en && addr == OFS_IRQ_STATUS),
      .mask_wr(wr_en && addr == OFS_IRQ_MASK),
      .wdata(wr_data[NUM_EV-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   assign rd_data = st_ff.rdata;
   assign core_start = st_ff.core_start;
   assign core_chan = st_ff.chan;
   assign core_abort = st_ff.core_abort;
   assign monitor_a_irq = hit_a;
   assign monitor_b_irq = hit_b;
   assign soft_done_irq = st_ff.soft_done;

   a_mon_irq_sticky: assert property (
      @(posedge clk) disable iff (sys_rst)
      monitor_a_irq |=> irq_status[EV_MON_A])
      else $error("monitor interrupt not latched in status");

   a_stored_kept: assert property (
      @(posedge clk) disable iff (sys_rst)
      st_ff.stored[0] && !(rd_res && rd_idx == 4'h0) |=> st_ff.stored[0])
      else $error("stored flag cleared without a read");

   a_overrun_set: assert property (
      @(posedge clk) disable iff (sys_rst)
      store_v && st_ff.idx == 4'h0 && st_ff.stored[0] &&
      !(rd_res && rd_idx == 4'h0) |=> st_ff.ovr[0] && st_ff.stored[0])
      else $error("overwrite of unread result missed overrun");

   a_soft_done_end: assert property (
      @(posedge clk) disable iff (sys_rst)
      soft_done_irq |-> $past(st_ff.idx) == LAST_SLOT &&
      st_ff.state == ADM_IDLE)
      else $error("soft interrupt before last slot");

   a_abort_no_store: assert property (
      @(posedge clk) disable iff (sys_rst)
      en_clear && st_ff.state == ADM_CONV |=>
      core_abort && st_ff.state == ADM_IDLE &&
      st_ff.stored == $past(st_ff.stored) && !soft_done_irq)
      else $error("disable did not abort or still stored");

   a_mon_b_irq_sticky: assert property (
      @(posedge clk) disable iff (sys_rst)
      monitor_b_irq |=> irq_status[EV_MON_B])
      else $error("monitor b interrupt not latched in status");

   a_soft_irq_sticky: assert property (
      @(posedge clk) disable iff (sys_rst)
      soft_done_irq |=> irq_status[EV_SOFT])
      else $error("soft interrupt not latched in status");

   a_read_clears_flags: assert property (
      @(posedge clk) disable iff (sys_rst)
      rd_res && rd_idx == 4'h0 && !(store_v && st_ff.idx == 4'h0) |=>
      !st_ff.stored[0] && !st_ff.ovr[0])
      else $error("read of result did not clear its flags");

   a_overrun_needs_store: assert property (
      @(posedge clk) disable iff (sys_rst)
      !st_ff.ovr[0] && !(store_v && st_ff.idx == 4'h0) |=> !st_ff.ovr[0])
      else $error("overrun flag set without a store");

   a_store_writes_result: assert property (
      @(posedge clk) disable iff (sys_rst)
      store_v && st_ff.idx == 4'h0 |=>
      st_ff.stored[0] && st_ff.res[0] == $past(core_data))
      else $error("store did not write result and stored flag");

   a_start_in_conv: assert property (
      @(posedge clk) disable iff (sys_rst)
      core_start |-> st_ff.state == ADM_CONV)
      else $error("conversion start outside a conversion");

   a_chan_from_slot: assert property (
      @(posedge clk) disable iff (sys_rst)
      core_start && !$past(wr_en) |->
      core_chan == st_ff.slot[st_ff.idx][CHAN_W-1:0])
      else $error("conversion started on wrong channel");

   a_abort_in_scan: assert property (
      @(posedge clk) disable iff (sys_rst)
      en_clear && st_ff.state == ADM_SCAN |=>
      !core_start && !core_abort && st_ff.state == ADM_IDLE)
      else $error("disable during scan did not stop quietly");

   a_idle_no_store: assert property (
      @(posedge clk) disable iff (sys_rst)
      st_ff.state != ADM_CONV && !rd_res |=>
      st_ff.stored == $past(st_ff.stored))
      else $error("result stored outside a conversion");
endmodule : adm_core

// ==== adm_core_model.sv ====
module adm_core_model import adm_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic core_start,
   input wire logic [4:0] core_chan,
   input wire logic core_abort,
   input wire logic [3:0] lat,
   input wire logic [11:0] data_in,
   output logic core_done,
   output logic [11:0] core_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic busy = 1'b0;
   logic [3:0] cnt = 4'h0;
   initial
   begin
      core_done = 1'b0;
      core_data = 12'h000;
   end
   // Data line flips every cycle outside the one valid cycle
   always @(posedge clk)
   begin
      core_done <= 1'b0;
      core_data <= ~core_data;
      if (sys_rst || core_abort)
         busy <= 1'b0;
      else if (core_start)
      begin
         busy <= 1'b1;
         cnt <= lat;
      end
      else if (busy && cnt == 4'h0)
      begin
         busy <= 1'b0;
         core_done <= 1'b1;
         core_data <= data_in;
      end
      else if (busy)
         cnt <= cnt - 4'h1;
   end
endmodule : adm_core_model

// ==== adm_irq.sv ====
module adm_irq import adm_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] event_in,
   input wire logic status_wr,
   input wire logic mask_wr,
   input wire logic [2:0] wdata,
   output logic [2:0] status,
   output logic [2:0] mask,
   output logic irq
);
   typedef struct packed {
      logic [2:0] status;
      logic [2:0] mask;
   } adm_irq_s;

   adm_irq_s st_ff;
   adm_irq_s nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      // Set wins over a write-one clear in the same cycle
      if (status_wr)
         nxt_st.status = st_ff.status & ~wdata;
      nxt_st.status = nxt_st.status | event_in;
      if (mask_wr)
         nxt_st.mask = wdata;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_ff.status <= 3'h0;
         st_ff.mask <= IRQ_MASK_RST;
      end
      else
         st_ff <= nxt_st;
   end

   assign status = st_ff.status;
   assign mask = st_ff.mask;
   assign irq = |(st_ff.status & st_ff.mask);
endmodule : adm_irq

// ==== adm_monitor.sv ====
module adm_monitor import adm_pkg::*; (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic store_valid,
   input wire logic [3:0] store_index,
   input wire logic [11:0] store_data,
   input wire logic enable,
   input wire logic condition,
   input wire logic [3:0] select,
   input wire logic [11:0] value,
   output logic hit
);
   typedef struct packed {
      logic hit;
   } adm_mon_s;

   adm_mon_s st_ff;
   adm_mon_s nxt_st;

   always_comb
   begin
      nxt_st.hit = enable && store_valid && (store_index == select) &&
         meets(store_data, value, condition);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign hit = st_ff.hit;

   a_hit_needs_enable: assert property (
      @(posedge clk) disable iff (sys_rst) hit |-> $past(enable))
      else $error("monitor hit while disabled");

   a_hit_on_store: assert property (
      @(posedge clk) disable iff (sys_rst)
      hit |-> $past(store_valid) && $past(store_index) == $past(select))
      else $error("monitor hit without a store to its register");

   a_hit_on_match: assert property (
      @(posedge clk) disable iff (sys_rst)
      enable && store_valid && store_index == select &&
      meets(store_data, value, condition) |=> hit)
      else $error("matching store did not raise monitor hit");

   a_other_reg_quiet: assert property (
      @(posedge clk) disable iff (sys_rst)
      store_valid && store_index != select |=> !hit)
      else $error("store to other register raised monitor hit");
endmodule : adm_monitor

// ==== adm_pkg.sv ====
package adm_pkg;
   localparam int DATA_W = 12;
   localparam int NUM_RES = 12;
   localparam int CHAN_W = 5;
   localparam int NUM_EV = 3;
   localparam logic [3:0] LAST_SLOT = 4'hB;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_SLOT_0_3 = 8'h04;
   localparam logic [7:0] OFS_SLOT_4_7 = 8'h08;
   localparam logic [7:0] OFS_SLOT_8_11 = 8'h0C;
   localparam logic [7:0] OFS_MON_A_CTRL = 8'h10;
   localparam logic [7:0] OFS_MON_B_CTRL = 8'h14;
   localparam logic [7:0] OFS_MON_A_VALUE = 8'h18;
   localparam logic [7:0] OFS_MON_B_VALUE = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   localparam logic [7:0] OFS_RESULT_BASE = 8'h40;
   localparam logic [7:0] OFS_RESULT_LAST = 8'h6C;

   // Field positions
   localparam int MODE_EN_BIT = 0;
   localparam int MODE_START_BIT = 1;
   localparam int MODE_BUSY_BIT = 2;
   localparam int SLOT_EN_BIT = 7;
   localparam int MON_EN_BIT = 7;
   localparam int MON_COND_BIT = 4;
   localparam int RES_STORED_BIT = 31;
   localparam int RES_OVR_BIT = 30;
   localparam int EV_SOFT = 0;
   localparam int EV_MON_A = 1;
   localparam int EV_MON_B = 2;

   // Writable bits and reset values
   localparam logic [31:0] SLOT_WR_MASK = 32'h9F9F9F9F;
   localparam logic [7:0] MON_CTRL_MASK = 8'h9F;
   localparam logic [95:0] SLOT_RST = 96'h0;
   localparam logic [7:0] MON_CTRL_RST = 8'h00;
   localparam logic [11:0] MON_VALUE_RST = 12'h000;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   typedef enum logic [1:0] {ADM_IDLE, ADM_SCAN, ADM_CONV} adm_seq_e;

   function automatic logic res_hit(input logic [7:0] a);
      return (a >= OFS_RESULT_BASE) && (a <= OFS_RESULT_LAST) &&
         (a[1:0] == 2'h0);
   endfunction : res_hit

   function automatic logic [3:0] res_sel(input logic [7:0] a);
      logic [7:0] d;
      d = a - OFS_RESULT_BASE;
      return d[5:2];
   endfunction : res_sel

   // Condition 1: result at or above value; 0: result below value
   function automatic logic meets(input logic [11:0] data,
      input logic [11:0] value, input logic cond);
      return cond ? (data >= value) : (data < value);
   endfunction : meets
endpackage : adm_pkg

// ==== test_adc_result_monitor_and_soft_conversion.sv ====
module test_adc_result_monitor_and_soft_conversion;
   timeunit 1ns;
   timeprecision 1ns;
   import adm_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [3:0] lat = 4'h2;
   logic [11:0] data_in = 12'h000;
   logic [31:0] rd_data, got;
   logic core_start, core_abort, core_done, irq;
   logic monitor_a_irq, monitor_b_irq, soft_done_irq;
   logic [4:0] core_chan;
   logic [11:0] core_data, d;
   logic p1 = 1'b0;
   logic p2 = 1'b0;
   logic [31:0] model [12] = '{default: 32'h0};
   logic [7:0] rz [5] = '{OFS_MODE, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'h30,
      OFS_RESULT_BASE};
   int n_errors = 0;
   int comparisons = 0;
   int n_a = 0, n_b = 0, n_soft = 0, n_done = 0, n_abort = 0;
   int exp_done = 0;
   int n_st = 0;
   logic [31:0] slot_w = 32'h0;

   always #25 clk = ~clk;

   adm_core DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .core_start(core_start), .core_chan(core_chan),
      .core_abort(core_abort), .core_done(core_done),
      .core_data(core_data), .monitor_a_irq(monitor_a_irq),
      .monitor_b_irq(monitor_b_irq), .soft_done_irq(soft_done_irq),
      .irq(irq));

   adm_core_model core_model (.clk(clk), .sys_rst(sys_rst),
      .core_start(core_start), .core_chan(core_chan),
      .core_abort(core_abort), .lat(lat), .data_in(data_in),
      .core_done(core_done), .core_data(core_data));

   task automatic test_done();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task automatic fail(input string m);
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
      comparisons++;
      if (g !== e)
         fail(m);
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 got = rd_data;
   endtask : rd

   // Reading a result clears both flags in the model too
   task automatic chk_res(input int s);
      rd(8'(OFS_RESULT_BASE + 4 * s));
      chk(got, model[s], "result word");
      model[s] = {20'h0, model[s][11:0]};
   endtask : chk_res

   // Runs slots 0 to 2 and waits for the soft done pulse
   task automatic go();
      int k;
      int i;
      k = n_soft;
      exp_done += 3;
      for (i = 0; i < 3; i++)
         model[i] = {1'b1, model[i][31] | model[i][30], 18'h0, data_in};
      wr(OFS_MODE, 32'h3);
      for (i = 0; i < 400 && n_soft == k; i++)
      begin
         @(posedge clk);
         #1;
      end
      if (n_soft == k)
      begin
         fail("no soft done");
         test_done();
      end
   endtask : go

   always @(posedge clk)
   begin
      p1 <= core_done;
      p2 <= p1;
      if (!sys_rst)
      begin
         n_a += monitor_a_irq;
         n_b += monitor_b_irq;
         n_soft += soft_done_irq;
         n_done += core_done;
         n_abort += core_abort;
         if (core_start)
         begin
            chk(core_chan, slot_w[8 * (n_st % 3) +: 5], "channel");
            n_st++;
         end
         if ((monitor_a_irq || monitor_b_irq) && !(p1 || p2))
            fail("monitor pulse without a store");
         if (soft_done_irq && n_done != exp_done)
            fail("soft done before all slots");
      end
   end

   initial
   begin
      void'($urandom(52281));
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      wr(OFS_RESULT_BASE, 32'hFFFFFFFF);
      foreach (rz[i])
      begin
         rd(rz[i]);
         chk(got, 32'h0, "reset or read-only value");
      end
      $display("test reset done");
      d = 12'($urandom_range(4094, 1));
      data_in <= d;
      slot_w = 32'h00808080 | ($urandom & 32'h001F1F1F);
      wr(OFS_SLOT_0_3, slot_w);
      wr(OFS_MON_A_VALUE, {20'h0, d});
      wr(OFS_MON_A_CTRL, 32'h91);
      wr(OFS_MON_B_VALUE, 32'hFFF);
      wr(OFS_MON_B_CTRL, 32'h87);
      go();
      chk(n_a, 1, "monitor a count");
      chk(n_b, 0, "monitor b watched other result");
      chk(n_soft, 1, "soft done count");
      chk_res(1);
      rd(OFS_IRQ_STATUS);
      chk(got, 32'h3, "status");
      chk(irq, 0, "irq masked");
      wr(OFS_IRQ_MASK, 32'h7);
      #1 chk(irq, 1, "irq unmasked");
      wr(OFS_IRQ_STATUS, 32'h3);
      #1 chk(irq, 0, "irq cleared");
      $display("test monitor match done");
      d = 12'($urandom_range(4094, 1));
      data_in <= d;
      wr(OFS_MON_A_VALUE, 32'h0);
      wr(OFS_MON_A_CTRL, 32'h11);
      wr(OFS_MON_B_VALUE, {20'h0, d + 12'h001});
      wr(OFS_MON_B_CTRL, 32'h82);
      go();
      chk(n_a, 1, "disabled monitor fired");
      chk(n_b, 1, "monitor b count");
      chk_res(0);
      chk_res(0);
      chk_res(1);
      chk_res(2);
      wr(OFS_IRQ_STATUS, 32'h7);
      $display("test overrun done");
      lat <= 4'hF;
      data_in <= ~d;
      wr(OFS_MODE, 32'h3);
      repeat (4) @(posedge clk);
      wr(OFS_MODE, 32'h0);
      repeat (30) @(posedge clk);
      chk(n_abort, 1, "abort pulse");
      chk(n_soft, 2, "soft done after abort");
      chk_res(0);
      rd(OFS_MODE);
      chk(got, 32'h0, "mode after abort");
      $display("test abort done");
      wr(OFS_SLOT_0_3, 32'h0);
      wr(OFS_MODE, 32'h3);
      wr(OFS_MODE, 32'h0);
      repeat (20) @(posedge clk);
      chk(n_soft, 2, "soft done after scan abort");
      chk(n_abort, 1, "abort pulse during scan");
      $display("test scan abort done");
      test_done();
   end
endmodule : test_adc_result_monitor_and_soft_conversion
